// ===== hdl/deb_ext_bus_ctrl.sv
// External memory and I/O bus control with AXI4-Lite configuration registers.
// Operation
// R1: While reset is low, stop the core and reinitialize all control state.
// R2: After reset release, start the core at program address 0ff80.
// R3: Strap low at reset maps internal ROM into top 4K program words.
// R4: Strap high at reset sends those program addresses to external memory.
// R5: Strap sampled only in reset; mode register bit may override it.
// R6: Condition true when input low; XC samples at decode, others at read.
// R7: Flag output latched; set instr raises, clear or status load lowers, reset raises.
// R8: Space selects high except low while valid address of that space.
// R9: Memory strobe low only during external data or program access.
// R10: I/O strobe low only during external I/O access.
// R11: Direction output rests high, low only during external writes.
// R12: Outside device holds ready low until done; we resample each cycle.
// R13: Ready sampled only with two or more wait states, after they finish.
// R14: Other master requests hold; once acknowledged, bus lines float.
// R15: Acknowledge asserted while holding, control and bus lines floated.
// R16: Selects, strobes, direction float in hold and when output disable low.
// R17: Wait-complete low at first software wait state, high at last one.
// R18: Wait-complete looped to ready yields exactly one external wait state.
// R19: Fetch indicator low while an instruction address is on the bus.
// R20: Hold acknowledged only after any external access in progress completes.
`timescale 1ns/1ps
module deb_ext_bus_ctrl
    import deb_pkg::*;
(
    input logic aclk,
    input logic aresetn,
    input logic [7:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [7:0] s_axi_araddr,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input logic s_axi_rready,
    input deb_req_t core_req,
    output logic core_ready,
    output deb_rsp_t core_rsp,
    input deb_cmd_t core_cmd,
    output deb_core_ctl_t core_ctl,
    input logic rom_map_select,
    input logic branch_condition_input_n,
    input logic ready,
    input logic hold_req_n,
    input logic output_disable_n,
    input logic [15:0] data_in,
    output deb_pins_t pins
);

    // ==========================================================
    // State
    // ==========================================================
    deb_state_t st_ff;
    deb_state_t nxt_st;
    logic accept;
    logic rom_hit;
    logic finish;
    logic ready_phase;
    logic [3:0] nxt_cnt;

    assign accept = core_req.valid && st_ff.core_ready;
    assign rom_hit = (core_req.space == SP_PROG) && !st_ff.rom_ext
                     && (core_req.addr >= ROM_BASE);
    assign ready_phase = (st_ff.waits >= MIN_READY_WAITS);

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        nxt_st = st_ff;
        finish = 1'b0;
        nxt_cnt = 4'h0;
        nxt_st.core.start = 1'b0;
        nxt_st.rsp.done = 1'b0;
        nxt_st.rsp.internal = 1'b0;
        if (!aresetn) begin
            nxt_st.fsm = ST_IDLE; // [R1]
            nxt_st.cnt = 4'h0;
            nxt_st.waits = 3'h0;
            nxt_st.rom_strap = rom_map_select; // [R5]
            nxt_st.rom_ext = rom_map_select; // [R3] [R4]
            nxt_st.cfg_mem = CFG_MEM_RST;
            nxt_st.cfg_io = CFG_IO_RST;
            nxt_st.cond_xc = 1'b0;
            nxt_st.cond_rd = 1'b0;
            nxt_st.core_ready = 1'b0;
            nxt_st.core.run = 1'b0; // [R1]
            nxt_st.core.boot_addr = BOOT_VECTOR; // [R2]
            nxt_st.core.cond_exec = 1'b0;
            nxt_st.rsp.rdata = 16'h0000;
            nxt_st.pins.data_space_select_n = 1'b1;
            nxt_st.pins.program_space_select_n = 1'b1;
            nxt_st.pins.io_space_select_n = 1'b1;
            nxt_st.pins.memory_strobe_n = 1'b1;
            nxt_st.pins.io_device_strobe_n = 1'b1;
            nxt_st.pins.read_not_write = 1'b1;
            nxt_st.pins.wait_complete_output_n = 1'b1;
            nxt_st.pins.instruction_fetch_indicator_n = 1'b1;
            nxt_st.pins.bus_release_ack_n = 1'b1;
            nxt_st.pins.external_flag_output = 1'b1; // [R7]
            nxt_st.pins.ctrl_oe = 1'b0;
            nxt_st.pins.misc_oe = 1'b0;
            nxt_st.pins.addr = 16'h0000;
            nxt_st.pins.data_out = 16'h0000;
            nxt_st.pins.data_oe = 1'b0;
            nxt_st.aw_got = 1'b0;
            nxt_st.aw_addr = 8'h00;
            nxt_st.w_got = 1'b0;
            nxt_st.w_data = 32'h0000_0000;
            nxt_st.w_strb = 4'h0;
            nxt_st.awready = 1'b0;
            nxt_st.wready = 1'b0;
            nxt_st.bvalid = 1'b0;
            nxt_st.bresp = RESP_OKAY;
            nxt_st.arready = 1'b0;
            nxt_st.rvalid = 1'b0;
            nxt_st.rresp = RESP_OKAY;
            nxt_st.rdata = 32'h0000_0000;
        end else begin
            // Core start pulse in the first cycle after release.
            nxt_st.core.run = 1'b1;
            nxt_st.core.start = !st_ff.core.run; // [R2]

            // Branch condition capture per pipeline phase.
            if (core_cmd.decode_phase && core_cmd.is_xc) begin
                nxt_st.cond_xc = !branch_condition_input_n; // [R6]
            end
            if (core_cmd.read_phase && !core_cmd.is_xc) begin
                nxt_st.cond_rd = !branch_condition_input_n; // [R6]
            end
            nxt_st.core.cond_exec = core_cmd.is_xc ? nxt_st.cond_xc : nxt_st.cond_rd;

            // Latched software flag; set takes priority over clear.
            if (core_cmd.set_flag) begin
                nxt_st.pins.external_flag_output = 1'b1; // [R7]
            end else if (core_cmd.clr_flag || core_cmd.st1_load) begin
                nxt_st.pins.external_flag_output = 1'b0; // [R7]
            end

            // AXI4-Lite write channel.
            if (st_ff.awready && s_axi_awvalid) begin
                nxt_st.aw_got = 1'b1;
                nxt_st.aw_addr = s_axi_awaddr;
            end
            if (st_ff.wready && s_axi_wvalid) begin
                nxt_st.w_got = 1'b1;
                nxt_st.w_data = s_axi_wdata;
                nxt_st.w_strb = s_axi_wstrb;
            end
            if (st_ff.bvalid && s_axi_bready) begin
                nxt_st.bvalid = 1'b0;
            end
            if (nxt_st.aw_got && nxt_st.w_got && !nxt_st.bvalid) begin
                nxt_st.aw_got = 1'b0;
                nxt_st.w_got = 1'b0;
                nxt_st.bvalid = 1'b1;
                nxt_st.bresp = RESP_OKAY;
                case ({nxt_st.aw_addr[7:2], 2'b00})
                    REG_CFG: begin
                        if (nxt_st.w_strb[0]) begin
                            nxt_st.cfg_mem = nxt_st.w_data[CFG_MEM_LSB +: 3];
                            nxt_st.cfg_io = nxt_st.w_data[CFG_IO_LSB +: 3];
                        end
                    end
                    REG_MODE: begin
                        if (nxt_st.w_strb[0]) begin
                            nxt_st.rom_ext = nxt_st.w_data[MODE_EXT_BIT]; // [R5]
                        end
                    end
                    REG_STATUS: begin
                        nxt_st.bresp = RESP_OKAY;
                    end
                    default: begin
                        nxt_st.bresp = RESP_DECERR;
                    end
                endcase
            end
            nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
            nxt_st.wready = !nxt_st.w_got && !nxt_st.bvalid;

            // AXI4-Lite read channel.
            if (st_ff.rvalid && s_axi_rready) begin
                nxt_st.rvalid = 1'b0;
            end
            if (st_ff.arready && s_axi_arvalid) begin
                nxt_st.rvalid = 1'b1;
                nxt_st.rresp = RESP_OKAY;
                nxt_st.rdata = 32'h0000_0000;
                case ({s_axi_araddr[7:2], 2'b00})
                    REG_CFG: begin
                        nxt_st.rdata[CFG_MEM_LSB +: 3] = st_ff.cfg_mem;
                        nxt_st.rdata[CFG_IO_LSB +: 3] = st_ff.cfg_io;
                    end
                    REG_MODE: begin
                        nxt_st.rdata[MODE_EXT_BIT] = st_ff.rom_ext;
                    end
                    REG_STATUS: begin
                        nxt_st.rdata[4:0] = {st_ff.core.cond_exec,
                                             st_ff.fsm == ST_ACCESS,
                                             st_ff.fsm == ST_HOLD,
                                             st_ff.pins.external_flag_output,
                                             st_ff.rom_strap};
                    end
                    default: begin
                        nxt_st.rresp = RESP_DECERR;
                    end
                endcase
            end
            nxt_st.arready = !nxt_st.rvalid;

            // External bus sequencer.
            case (st_ff.fsm)
                ST_IDLE: begin
                    if (accept && rom_hit) begin
                        nxt_st.rsp.done = 1'b1; // [R3]
                        nxt_st.rsp.internal = 1'b1;
                    end else if (accept) begin
                        nxt_st.fsm = ST_ACCESS;
                        nxt_st.cnt = 4'h0;
                        nxt_st.waits = (core_req.space == SP_IO) ? st_ff.cfg_io
                                                                  : st_ff.cfg_mem;
                        nxt_st.pins.addr = core_req.addr;
                        nxt_st.pins.data_out = core_req.wdata;
                        nxt_st.pins.data_space_select_n = !(core_req.space == SP_DATA); // [R8]
                        nxt_st.pins.program_space_select_n = !(core_req.space == SP_PROG); // [R8]
                        nxt_st.pins.io_space_select_n = !(core_req.space == SP_IO); // [R8]
                        nxt_st.pins.memory_strobe_n = (core_req.space == SP_IO); // [R9]
                        nxt_st.pins.io_device_strobe_n = !(core_req.space == SP_IO); // [R10]
                        nxt_st.pins.read_not_write = !core_req.write; // [R11]
                        nxt_st.pins.instruction_fetch_indicator_n = !core_req.fetch; // [R19]
                    end else if (!hold_req_n) begin
                        nxt_st.fsm = ST_HOLD; // [R14] [R20]
                    end
                end
                ST_ACCESS: begin
                    if (!ready_phase) begin
                        finish = (st_ff.cnt == {1'b0, st_ff.waits});
                    end else begin
                        finish = (st_ff.cnt > {1'b0, st_ff.waits}) && ready; // [R12] [R13] [R18]
                    end
                    if (finish) begin
                        nxt_st.fsm = ST_IDLE;
                        nxt_st.rsp.done = 1'b1;
                        nxt_st.rsp.rdata = data_in;
                        nxt_st.pins.data_space_select_n = 1'b1; // [R8]
                        nxt_st.pins.program_space_select_n = 1'b1;
                        nxt_st.pins.io_space_select_n = 1'b1;
                        nxt_st.pins.memory_strobe_n = 1'b1; // [R9]
                        nxt_st.pins.io_device_strobe_n = 1'b1; // [R10]
                        nxt_st.pins.read_not_write = 1'b1; // [R11]
                        nxt_st.pins.instruction_fetch_indicator_n = 1'b1; // [R19]
                    end else if (st_ff.cnt != 4'hf) begin
                        nxt_cnt = st_ff.cnt + 4'h1;
                        nxt_st.cnt = nxt_cnt;
                    end else begin
                        nxt_cnt = st_ff.cnt;
                    end
                end
                ST_HOLD: begin
                    if (hold_req_n) begin
                        nxt_st.fsm = ST_IDLE;
                    end
                end
                default: begin
                    nxt_st.fsm = ST_IDLE;
                end
            endcase

            // Wait-complete low from the first wait state up to the last one.
            nxt_st.pins.wait_complete_output_n = !((nxt_st.fsm == ST_ACCESS) && ready_phase
                && (nxt_cnt != 4'h0) && (nxt_cnt < {1'b0, st_ff.waits})); // [R17]

            // Hold acknowledge and output enables.
            nxt_st.pins.bus_release_ack_n = !(nxt_st.fsm == ST_HOLD); // [R15]
            nxt_st.pins.ctrl_oe = output_disable_n && (nxt_st.fsm != ST_HOLD); // [R16]
            nxt_st.pins.misc_oe = output_disable_n;
            nxt_st.pins.data_oe = nxt_st.pins.ctrl_oe && (nxt_st.fsm == ST_ACCESS)
                                  && !nxt_st.pins.read_not_write; // [R14]
            nxt_st.core_ready = (nxt_st.fsm == ST_IDLE) && hold_req_n && !nxt_st.rsp.done;
        end
    end

    // ==========================================================
    // Register
    // ==========================================================
    always_ff @(posedge aclk) begin
        st_ff <= nxt_st;
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign s_axi_awready = st_ff.awready;
    assign s_axi_wready = st_ff.wready;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_arready = st_ff.arready;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;
    assign s_axi_rvalid = st_ff.rvalid;
    assign core_ready = st_ff.core_ready;
    assign core_rsp = st_ff.rsp;
    assign core_ctl = st_ff.core;
    assign pins = st_ff.pins;

endmodule : deb_ext_bus_ctrl

// ===== pkg/deb_pkg.sv
// Constants and carrier types for the external bus control block.
package deb_pkg;
    // ==========================================================
    // Addresses, strap behaviour and ready wait threshold
    // ==========================================================
    localparam logic [15:0] BOOT_VECTOR = 16'hff80;
    localparam logic [15:0] ROM_BASE = 16'hf000;
    localparam logic [2:0] MIN_READY_WAITS = 3'h2;

    // ==========================================================
    // Register map (byte offsets) and fields
    // ==========================================================
    localparam logic [7:0] REG_CFG = 8'h00;
    localparam logic [7:0] REG_MODE = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam int CFG_MEM_LSB = 0;
    localparam int CFG_IO_LSB = 4;
    localparam int MODE_EXT_BIT = 0;
    localparam logic [2:0] CFG_MEM_RST = 3'h0;
    localparam logic [2:0] CFG_IO_RST = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [1:0] {SP_DATA, SP_PROG, SP_IO} deb_space_t;
    typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_HOLD} deb_fsm_t;

    typedef struct packed {
        logic valid;
        deb_space_t space;
        logic write;
        logic fetch;
        logic [15:0] addr;
        logic [15:0] wdata;
    } deb_req_t;

    typedef struct packed {
        logic done;
        logic internal;
        logic [15:0] rdata;
    } deb_rsp_t;

    typedef struct packed {
        logic decode_phase;
        logic read_phase;
        logic is_xc;
        logic set_flag;
        logic clr_flag;
        logic st1_load;
    } deb_cmd_t;

    typedef struct packed {
        logic run;
        logic start;
        logic [15:0] boot_addr;
        logic cond_exec;
    } deb_core_ctl_t;

    typedef struct packed {
        logic data_space_select_n;
        logic program_space_select_n;
        logic io_space_select_n;
        logic memory_strobe_n;
        logic io_device_strobe_n;
        logic read_not_write;
        logic wait_complete_output_n;
        logic instruction_fetch_indicator_n;
        logic bus_release_ack_n;
        logic external_flag_output;
        logic ctrl_oe;
        logic misc_oe;
        logic [15:0] addr;
        logic [15:0] data_out;
        logic data_oe;
    } deb_pins_t;

    typedef struct packed {
        deb_fsm_t fsm;
        logic [3:0] cnt;
        logic [2:0] waits;
        logic rom_ext;
        logic rom_strap;
        logic [2:0] cfg_mem;
        logic [2:0] cfg_io;
        logic cond_xc;
        logic cond_rd;
        logic core_ready;
        deb_core_ctl_t core;
        deb_rsp_t rsp;
        deb_pins_t pins;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } deb_state_t;
endpackage : deb_pkg

// ===== tb/deb_ext_bus_checker.sv
// Concurrent checks on the pins and core side of the external bus control block.
`timescale 1ns/1ps
module deb_ext_bus_checker
    import deb_pkg::*;
(
    input logic aclk,
    input logic aresetn,
    input deb_rsp_t core_rsp,
    input deb_cmd_t core_cmd,
    input deb_core_ctl_t core_ctl,
    input logic ready,
    input logic output_disable_n,
    input deb_pins_t pins
);
    deb_pins_t p;
    logic acc;
    assign p = pins;
    assign acc = !p.memory_strobe_n || !p.io_device_strobe_n;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Last software wait state begins while the strobe is still low.
    sequence wc_end;
        $rose(p.wait_complete_output_n) && acc;
    endsequence
    mem_strobe_a: assert property (!p.memory_strobe_n |-> p.io_device_strobe_n
        && p.data_space_select_n != p.program_space_select_n) else $error("mem strobe");
    io_strobe_a: assert property (!p.io_device_strobe_n |-> !p.io_space_select_n
        && p.memory_strobe_n) else $error("io strobe");
    select_idle_a: assert property (!acc |-> p.data_space_select_n
        && p.program_space_select_n && p.io_space_select_n) else $error("select idle");
    dir_rest_a: assert property (!p.read_not_write |-> acc) else $error("direction");
    ready_early_a: assert property (wc_end |=> acc && !core_rsp.done)
        else $error("ready early");
    ready_take_a: assert property (wc_end ##1 ready |=> core_rsp.done && !acc)
        else $error("ready missed");
    ready_wait_a: assert property (wc_end ##1 !ready |=> acc && !core_rsp.done)
        else $error("ready ignored");
    hold_clean_a: assert property ($fell(p.bus_release_ack_n) |-> !$past(acc)
        && !p.ctrl_oe && !p.data_oe) else $error("hold entry");
    off_float_a: assert property (!output_disable_n |=> !p.ctrl_oe && !p.misc_oe)
        else $error("not floated");
    flag_set_a: assert property (core_cmd.set_flag |=> p.external_flag_output)
        else $error("flag not set");
    boot_start_a: assert property ($rose(core_ctl.run) |-> core_ctl.start
        && core_ctl.boot_addr == BOOT_VECTOR) else $error("boot start");
    fetch_prog_a: assert property (!p.instruction_fetch_indicator_n
        |-> !p.program_space_select_n) else $error("fetch indicator");
endmodule : deb_ext_bus_checker

bind deb_ext_bus_ctrl deb_ext_bus_checker u_deb_ext_bus_checker (.aclk(aclk),
    .aresetn(aresetn), .core_rsp(core_rsp), .core_cmd(core_cmd), .core_ctl(core_ctl),
    .ready(ready), .output_disable_n(output_disable_n), .pins(pins));

// ===== tb/deb_ext_bus_ctrl_bench.sv
// Self-checking bench for the external bus control block.
`timescale 1ns/1ps
module deb_ext_bus_ctrl_bench
    import deb_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn, rom_map_select, branch_condition_input_n, ready, hold_req_n;
    logic output_disable_n, core_ready, s_axi_bvalid, s_axi_bready, s_axi_rvalid, s_axi_rready;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_arvalid, s_axi_arready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, dly;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] data_in;
    deb_req_t core_req;
    deb_rsp_t core_rsp;
    deb_cmd_t core_cmd;
    deb_core_ctl_t core_ctl;
    deb_pins_t pins;
    int n_mismatch = 0;
    int n_compared = 0;
    int n;
    always #2 aclk = ~aclk;
    deb_ext_bus_ctrl u_deb_ext_bus_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_req, .core_ready,
        .core_rsp, .core_cmd, .core_ctl, .rom_map_select, .branch_condition_input_n, .ready,
        .hold_req_n, .output_disable_n, .data_in, .pins);
    deb_ext_mem u_deb_ext_mem (.aclk, .pins, .dly, .ready, .data_in);
    task automatic chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1) begin
            $display("BAD %0t %s", $time, m);
            n_mismatch++;
        end
    endtask : chk
    task automatic end_of_test;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test
    function automatic logic seen(input int k);
        case (k)
            0: return s_axi_arready;
            1: return s_axi_rvalid;
            2: return s_axi_bvalid;
            3: return core_ready;
            4: return core_rsp.done;
            default: return !pins.bus_release_ack_n;
        endcase
    endfunction : seen
    // Samples at negative edges, where outputs have settled.
    task automatic wt(input int k);
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (seen(k) !== 1'b1 && n < 60);
        if (n >= 60) begin
            chk(1'b0, "timeout");
            end_of_test();
        end
    endtask : wt
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ta = 1'b0, tw = 1'b0;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'h3};
        for (int i = 0; i < 60 && !(ta && tw); i++) begin
            @(negedge aclk);
            ta = ta || s_axi_awready;
            tw = tw || s_axi_wready;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b1;
        wt(2);
        chk(s_axi_bresp === r, "write resp");
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask : axw
    task automatic axr(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] r);
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        wt(0);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        wt(1);
        chk((s_axi_rdata & m) === e && s_axi_rresp === r, "read data");
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask : axr
    task automatic core(input deb_space_t sp, input logic wr, f, input logic [15:0] a, d,
            input int lat, input logic inr);
        @(posedge aclk);
        core_req <= {1'b1, sp, wr, f, a, d};
        wt(3);
        @(posedge aclk);
        core_req.valid <= 1'b0;
        wt(4);
        chk(n == lat + 1 && core_rsp.internal === inr && (wr || inr || core_rsp.rdata === d), "core");
    endtask : core
    initial begin
        {aresetn, hold_req_n, output_disable_n, branch_condition_input_n, rom_map_select} = 5'h0f;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0, 4'hf};
        {core_req, core_cmd} = '0;
        dly = 4'h0;
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        chk(core_ctl.run === 1'b0 && pins.external_flag_output === 1'b1, "in reset");
        @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(negedge aclk);
        chk(core_ctl.start === 1'b1 && core_ctl.boot_addr === BOOT_VECTOR, "boot");
        @(posedge aclk);
        rom_map_select <= 1'b0;
        axr(REG_MODE, 32'h1, 32'h1, RESP_OKAY);
        axr(REG_STATUS, 32'h3, 32'h3, RESP_OKAY);
        axr(REG_CFG, 32'h0, 32'h77, RESP_OKAY);
        axw(8'h0c, 32'h1, RESP_DECERR);
        axr(8'h0c, 32'h0, 32'hffffffff, RESP_DECERR);
        $display("test reset done");
        core(SP_PROG, 1'b1, 1'b0, 16'hf800, 16'h00a5, 1, 1'b0);
        core(SP_PROG, 1'b0, 1'b0, 16'hf800, 16'h00a5, 1, 1'b0);
        axw(REG_MODE, 32'h0, RESP_OKAY);
        core(SP_PROG, 1'b0, 1'b0, 16'hf000, 16'h0000, 0, 1'b1);
        core(SP_PROG, 1'b1, 1'b0, 16'hefff, 16'h0001, 1, 1'b0);
        core(SP_DATA, 1'b0, 1'b0, 16'hf800, 16'h00a5, 1, 1'b0);
        axw(REG_MODE, 32'h1, RESP_OKAY);
        $display("test rom map done");
        for (int w = 0; w < 4; w++) begin
            axw(REG_CFG, 32'(w), RESP_OKAY);
            core(SP_DATA, 1'b1, 1'b0, 16'(w), 16'(16'h1230 + w), w < 2 ? w + 1 : w + 2, 1'b0);
            core(SP_PROG, 1'b0, 1'b1, 16'(w), 16'(16'h1230 + w), w < 2 ? w + 1 : w + 2, 1'b0);
        end
        axw(REG_CFG, 32'h20, RESP_OKAY);
        core(SP_IO, 1'b1, 1'b0, 16'h0008, 16'h0bee, 4, 1'b0);
        core(SP_IO, 1'b0, 1'b0, 16'h0008, 16'h0bee, 4, 1'b0);
        axw(REG_CFG, 32'h2, RESP_OKAY);
        dly <= 4'h6;
        core(SP_DATA, 1'b0, 1'b0, 16'h0003, 16'h1233, 7, 1'b0);
        dly <= 4'h0;
        $display("test wait states done");
        axw(REG_CFG, 32'h3, RESP_OKAY);
        fork
            core(SP_DATA, 1'b1, 1'b0, 16'h0009, 16'h0777, 5, 1'b0);
            begin
                repeat (3) @(posedge aclk);
                hold_req_n <= 1'b0;
            end
        join
        wt(5);
        chk(!pins.ctrl_oe && !pins.data_oe && core_ready === 1'b0, "hold");
        axr(REG_STATUS, 32'h4, 32'h4, RESP_OKAY);
        @(posedge aclk);
        hold_req_n <= 1'b1;
        repeat (2) @(negedge aclk);
        chk(pins.bus_release_ack_n === 1'b1 && pins.ctrl_oe === 1'b1, "release");
        @(posedge aclk);
        output_disable_n <= 1'b0;
        repeat (2) @(negedge aclk);
        chk(pins.ctrl_oe === 1'b0 && pins.misc_oe === 1'b0, "disable");
        @(posedge aclk);
        output_disable_n <= 1'b1;
        $display("test hold done");
        for (int i = 0; i < 4; i++) begin
            @(posedge aclk);
            core_cmd <= {3'h0, !i[0], i == 1 || i == 2, i == 3};
            @(posedge aclk);
            core_cmd <= '0;
            @(negedge aclk);
            chk(pins.external_flag_output === !i[0], "flag");
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge aclk);
            branch_condition_input_n <= i[0];
            core_cmd <= {i[1], !i[1], i[1], 3'h0};
            @(posedge aclk);
            core_cmd <= '0;
            branch_condition_input_n <= !i[0];
            @(negedge aclk);
            chk(core_ctl.cond_exec === !i[0], "condition");
        end
        $display("test flag and condition done");
        end_of_test();
    end
endmodule : deb_ext_bus_ctrl_bench

// ===== tb/deb_ext_mem.sv
// Behavioural external memory that answers the block's bus cycles.
`timescale 1ns/1ps
module deb_ext_mem
    import deb_pkg::*;
(
    input logic aclk,
    input deb_pins_t pins,
    input logic [3:0] dly,
    output logic ready,
    output logic [15:0] data_in
);
    logic [15:0] mem [16];
    logic [15:0] last = 16'h0;
    logic [3:0] k = 4'h0;
    logic acc;
    logic rd;
    assign acc = pins.ctrl_oe && !(pins.memory_strobe_n && pins.io_device_strobe_n);
    assign rd = acc && pins.read_not_write;
    always @(posedge aclk) begin
        k <= acc ? k + {3'h0, k != 4'hf} : 4'h0;
        if (acc && !pins.read_not_write && pins.data_oe) begin
            mem[pins.addr[3:0]] <= pins.data_out;
        end
        if (rd) begin
            last <= data_in;
        end
    end
    // Zero delay loops wait-complete back; otherwise ready waits for the slow device.
    assign ready = (dly == 4'h0) ? pins.wait_complete_output_n : (acc && k >= dly);
    // A released data bus shows the inverse of the last word rather than holding it.
    assign data_in = rd ? mem[pins.addr[3:0]] : ~last;
endmodule : deb_ext_mem
